// File: ctt_clock_tree.sv
// Clock tree, dividers, interval counters and real-time tick with Avalon-MM registers
//
// The register offsets and register access over Avalon-MM are this design's own decisions.

// Overview of operation
// - Fast 5-bit counter wraps at terminal count
// - Fast terminal count interrupts only when enabled
// - Central counter interrupts periodically, can wake
// - Firmware reset clears central counter
// - Third-rate clock is low-speed divided by three
// - Bus, processor and digital divider clocks have 50% duty cycle; third-rate clock is high one third
// - Watch crystal drives once-per-second interrupt
// - Eight fabric clocks drive the eight dividers
// - Seven clock sources are selectable
// - Master clock is the source chosen by the select field
// - Bus divider from master feeds processor divider
// - Eight programmable 16-bit digital dividers
// - Startup clock 12 or 48 MHz by option
module ctt_clock_tree
  import ctt_pkg::*;
#(
  parameter int RTC_DIV = 32768
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Clock sources and fabric clocks
  input  wire logic [N_SRC-1:0] clk_src,
  input  wire logic [N_DCLK-1:0] fabric_clk,
  input  wire logic             fast_startup_strap,
  // Avalon-MM slave
  input  wire ctt_avm_req_t     avs_req,
  output logic [DW-1:0]         avs_readdata,
  output logic                  avs_waitrequest,
  // Derived clocks
  output logic                  master_clk_out,
  output logic                  bus_clk_out,
  output logic                  cpu_clk_out,
  output logic [N_DCLK-1:0]     dclk_out,
  output logic                  derived_third_rate_clock,
  // System signals
  output logic                  startup_clk_fast,
  output logic                  irq,
  output logic                  wake_req
);

  localparam logic [RTC_W-1:0] RTC_LAST = RTC_W'(RTC_DIV - 1);

  ctt_state_t        r;
  ctt_state_t        n;
  logic [N_IN-1:0]   rise;
  logic [7:0]        srise;
  logic [7:0]        slvl;
  logic              mtick;
  logic              btick;
  logic              ls;
  logic              fast_ev;
  logic              cen_ev;
  logic              rtc_ev;
  logic              cen_rst;
  logic              wr;
  logic              rd;
  logic [N_EV-1:0]   wclr;
  logic [N_EV-1:0]   ev;
  logic [DW-1:0]     rd_v;
  logic [2:0]        ix;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    n       = r;
    wclr    = '0;
    rd_v    = '0;
    ix      = avs_req.address[ADR_IX_MSB:ADR_IX_LSB];
    wr      = avs_req.write & r.ack;
    rd      = avs_req.read & ~r.ack;
    cen_rst = wr && avs_req.address == REG_CTRL && avs_req.writedata[CTRL_CEN_RST];

    // Three stages; a level change counts once stages two and three agree
    n.s1 = {fabric_clk, clk_src};
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < N_IN; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        n.lvl[i] = r.s3[i];
      end
    end
    rise  = n.lvl & ~r.lvl;
    // Select code 7 has no source and stalls the tree
    srise = {1'b0, rise[N_SRC-1:0]};
    slvl  = {1'b0, n.lvl[N_SRC-1:0]};
    mtick = srise[r.ctrl.master_sel];
    n.mclk = slvl[r.ctrl.master_sel];

    // Bus clock from master, processor clock from bus
    btick = mtick && r.bus.cnt == r.bus.act && !r.bus.out;
    n.bus = ctt_div_step(r.bus, mtick, r.bus_div);
    n.cpu = ctt_div_step(r.cpu, btick, r.cpu_div);
    for (int i = 0; i < N_DCLK; i++) begin
      n.dclk[i] = ctt_div_step(r.dclk[i], r.dsrc[i] ? rise[N_SRC + i] : mtick,
                               r.dclk_div[i]);
    end

    // Low-speed domain work
    ls = rise[SRC_LOW_SPEED];
    if (ls) begin
      n.third_cnt = (r.third_cnt == THIRD_LAST) ? 2'h0 : r.third_cnt + 2'h1;
    end
    // Only a third of the period high: an odd ratio cannot give 50%
    n.third = (n.third_cnt == 2'h0);

    fast_ev = ls && r.fast_cnt == r.fast_tc;
    if (ls) begin
      n.fast_cnt = fast_ev ? '0 : r.fast_cnt + 5'h01;
    end

    cen_ev = ls && r.cen_cnt == r.cen_tc;
    if (cen_rst) begin
      n.cen_cnt = '0;
    end else if (ls) begin
      n.cen_cnt = cen_ev ? '0 : r.cen_cnt + 16'h0001;
    end

    rtc_ev = rise[SRC_WATCH_XTAL] && r.rtc_cnt == RTC_LAST;
    if (rise[SRC_WATCH_XTAL]) begin
      n.rtc_cnt = rtc_ev ? '0 : r.rtc_cnt + 16'h0001;
    end

    // ----------------------------------------------------------------------
    // Register bus: one wait state on every access
    // ----------------------------------------------------------------------
    n.ack = (avs_req.read | avs_req.write) & ~r.ack;
    case (avs_req.address)
      REG_CTRL: begin
        rd_v[CTRL_SEL_MSB:CTRL_SEL_LSB] = r.ctrl.master_sel;
        rd_v[CTRL_FAST_EN]              = r.ctrl.fast_int_en;
        rd_v[CTRL_WAKE_EN]              = r.ctrl.wake_en;
      end
      REG_BUS_DIV:  rd_v[DIV_W-1:0]  = r.bus_div;
      REG_CPU_DIV:  rd_v[DIV_W-1:0]  = r.cpu_div;
      REG_FAST_TC:  rd_v[FAST_W-1:0] = r.fast_tc;
      REG_CEN_TC:   rd_v[CEN_W-1:0]  = r.cen_tc;
      REG_STATUS:   rd_v[N_EV-1:0]   = r.status;
      REG_MASK:     rd_v[N_EV-1:0]   = r.mask;
      REG_COUNT: begin
        rd_v[FAST_W-1:0]                    = r.fast_cnt;
        rd_v[CNT_CEN_LSB+CEN_W-1:CNT_CEN_LSB] = r.cen_cnt;
      end
      REG_DCLK_SRC: rd_v[N_DCLK-1:0] = r.dsrc;
      REG_INFO:     rd_v[INFO_FAST_ST] = r.fast_start;
      default: begin
        if (avs_req.address[ADR_PG_MSB:ADR_PG_LSB] == DCLK_PAGE) begin
          rd_v[DIV_W-1:0] = r.dclk_div[ix];
        end
      end
    endcase
    if (rd) begin
      n.rdata = rd_v;
    end

    if (wr) begin
      case (avs_req.address)
        REG_CTRL: begin
          n.ctrl.master_sel  = avs_req.writedata[CTRL_SEL_MSB:CTRL_SEL_LSB];
          n.ctrl.fast_int_en = avs_req.writedata[CTRL_FAST_EN];
          n.ctrl.wake_en     = avs_req.writedata[CTRL_WAKE_EN];
        end
        REG_BUS_DIV:  n.bus_div = avs_req.writedata[DIV_W-1:0];
        REG_CPU_DIV:  n.cpu_div = avs_req.writedata[DIV_W-1:0];
        REG_FAST_TC:  n.fast_tc = avs_req.writedata[FAST_W-1:0];
        REG_CEN_TC:   n.cen_tc  = avs_req.writedata[CEN_W-1:0];
        REG_STATUS:   wclr      = avs_req.writedata[N_EV-1:0];
        REG_MASK:     n.mask    = avs_req.writedata[N_EV-1:0];
        REG_DCLK_SRC: n.dsrc    = avs_req.writedata[N_DCLK-1:0];
        default: begin
          if (avs_req.address[ADR_PG_MSB:ADR_PG_LSB] == DCLK_PAGE) begin
            n.dclk_div[ix] = avs_req.writedata[DIV_W-1:0];
          end
        end
      endcase
    end

    // ----------------------------------------------------------------------
    // Interrupts: a new event beats a write-one-to-clear in the same cycle
    // ----------------------------------------------------------------------
    ev          = '0;
    ev[EV_FAST] = fast_ev & r.ctrl.fast_int_en;
    ev[EV_CEN]  = cen_ev;
    ev[EV_RTC]  = rtc_ev;
    n.status    = (r.status & ~wclr) | ev;
    n.irq       = |(n.status & n.mask);
    n.wake      = n.status[EV_CEN] & n.ctrl.wake_en;

    // Startup speed option caught once, first edge after reset release
    if (!r.strap_done) begin
      n.strap_done = 1'b1;
      n.fast_start = fast_startup_strap;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r                 <= '0;
      r.ctrl.master_sel <= SEL_RST;
      r.bus.act         <= DIV_RST;
      r.cpu.act         <= DIV_RST;
      r.bus_div         <= DIV_RST;
      r.cpu_div         <= DIV_RST;
      r.fast_tc         <= FAST_TC_RST;
      r.cen_tc          <= CEN_TC_RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign avs_waitrequest          = (avs_req.read | avs_req.write) & ~r.ack;
  assign avs_readdata             = r.rdata;
  assign master_clk_out           = r.mclk;
  assign bus_clk_out              = r.bus.out;
  assign cpu_clk_out              = r.cpu.out;
  assign derived_third_rate_clock = r.third;
  assign startup_clk_fast         = r.fast_start;
  assign irq                      = r.irq;
  assign wake_req                 = r.wake;
  always_comb begin
    for (int i = 0; i < N_DCLK; i++) begin
      dclk_out[i] = r.dclk[i].out;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_fast_wrap: assert property (fast_ev |=> r.fast_cnt == '0)
    else $error("fast counter did not wrap");
  a_fast_irq_on: assert property (fast_ev && r.ctrl.fast_int_en |=> r.status[EV_FAST])
    else $error("fast event lost");
  a_fast_irq_off: assert property (
    !r.ctrl.fast_int_en && !r.status[EV_FAST] |=> !r.status[EV_FAST])
    else $error("fast interrupt while disabled");
  a_cen_wake: assert property (cen_ev && r.ctrl.wake_en && n.ctrl.wake_en |=> wake_req)
    else $error("no wake after central event");
  a_cen_reset: assert property (cen_rst |=> r.cen_cnt == '0)
    else $error("central counter not reset");
  a_third_div: assert property (
    ls && r.third_cnt == THIRD_LAST |=> derived_third_rate_clock)
    else $error("third-rate clock not raised");
  a_third_low: assert property (
    ls && r.third_cnt != THIRD_LAST |=> !derived_third_rate_clock)
    else $error("third-rate clock not lowered");
  a_div_duty: assert property ($changed(r.bus.out) |-> r.bus.cnt == '0)
    else $error("bus clock toggled off count zero");
  a_rtc_sec: assert property (rtc_ev |=> r.status[EV_RTC])
    else $error("second tick lost");
  a_fabric_src: assert property (r.dsrc[0] && !rise[N_SRC] |=> $stable(r.dclk[0]))
    else $error("divider moved without fabric tick");
  a_bus_tick: assert property (!mtick |=> $stable(r.bus))
    else $error("bus divider moved without master tick");
  a_div_load: assert property ($changed(r.bus.act) |-> $past(r.bus.out) && !r.bus.out)
    else $error("divider setting loaded mid period");
  a_strap_hold: assert property (r.strap_done |=> $stable(startup_clk_fast))
    else $error("startup option changed");

  c_fast_irq: cover property (fast_ev && r.ctrl.fast_int_en);
  c_rtc_sec:  cover property (rtc_ev);
  c_cen_rst:  cover property (cen_rst);
  c_cpu_tick: cover property (btick && r.cpu.cnt == r.cpu.act);

endmodule : ctt_clock_tree

// File: ctt_clock_tree_test.sv
// Self-checking testbench of the clock tree and interval timers
module ctt_clock_tree_test
  import ctt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------
  // Stimulus and design
  // --------------------------------------------------------------
  localparam int RTCD = 4;
  localparam logic [AW-1:0] RA [8] = '{REG_BUS_DIV, REG_CPU_DIV, REG_FAST_TC, REG_CEN_TC,
                                       REG_MASK, REG_DCLK_SRC, 8'h40, 8'h5c};
  localparam int RM [8] = '{65535, 65535, 31, 65535, 7, 255, 65535, 65535};

  logic              clk    = 1'b0;
  logic              rst_n  = 1'b0;
  logic [N_SRC-1:0]  man    = '0;
  logic [N_SRC-1:0]  src_on = '0;
  logic [N_DCLK-1:0] fab_on = '0;
  logic [3:0]        ph     = 4'h0;
  logic              strap  = 1'b1;
  ctt_avm_req_t      req    = '0;
  logic [DW-1:0]     rdata;
  logic [DW-1:0]     rq;
  logic [N_DCLK-1:0] dclk;
  logic              mclk, bclk, cclk, third, fast_st, irq, wake, wreq;
  int                bad_count = 0;
  int                checks_done = 0;
  int                seed = 32'h06d83066;
  int                m_st = 0, m_mask = 0, m_fast = 0, m_cen = 0, m_rtc = 0;
  int                m_ftc = 31, m_ctc = 65535, m_fen = 0, m_wen = 0;

  // Sources run from one phase counter, so every edge lands on a known clk edge
  wire logic [11:0]       obs     = {third, cclk, bclk, mclk, dclk};
  wire logic [N_SRC-1:0]  clk_src = man | (src_on & {N_SRC{ph[2]}});
  wire logic [N_DCLK-1:0] fab     = fab_on & {N_DCLK{ph[2]}};

  initial begin
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    ph <= ph + 4'h1;
  end

  ctt_clock_tree #(.RTC_DIV(RTCD)) DUT (
    .clk(clk), .rst_n(rst_n), .clk_src(clk_src), .fabric_clk(fab),
    .fast_startup_strap(strap), .avs_req(req), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .master_clk_out(mclk), .bus_clk_out(bclk),
    .cpu_clk_out(cclk), .dclk_out(dclk), .derived_third_rate_clock(third),
    .startup_clk_fast(fast_st), .irq(irq), .wake_req(wake)
  );

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // Waitrequest sampled at each rising edge; the edge that sees it low completes the access
  task automatic xfer(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{read: ~wr, write: wr, address: a, writedata: d};
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    rq = rdata;
    req <= '0;
    check(n < 100, 1'b1);
  endtask : xfer

  task automatic wr(input logic [AW-1:0] a, input int d);
    xfer(1'b1, a, d);
    case (a)
      REG_CTRL: begin
        m_fen = d[3];
        m_wen = d[4];
        if (d[5]) m_cen = 0;
      end
      REG_FAST_TC: m_ftc = d & 31;
      REG_CEN_TC:  m_ctc = d & 65535;
      REG_STATUS:  m_st = m_st & ~d;
      REG_MASK:    m_mask = d & 7;
      default: ;
    endcase
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, input int exp);
    xfer(1'b0, a, '0);
    check(rq, exp);
  endtask : rd

  task automatic chk_ev;
    rd(REG_STATUS, m_st);
    check(irq, |(m_st & m_mask));
    check(wake, m_st[1] & m_wen);
  endtask : chk_ev

  // One slow source period of 9 clk, with the model stepped per rising edge
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge clk);
      man[idx] <= 1'b1;
      repeat (4) @(posedge clk);
      man[idx] <= 1'b0;
      repeat (4) @(posedge clk);
      if (idx == SRC_LOW_SPEED) begin
        if (m_fast == m_ftc) begin
          m_fast = 0;
          if (m_fen) m_st = m_st | 1;
        end else m_fast++;
        if (m_cen == m_ctc) begin
          m_cen = 0;
          m_st = m_st | 2;
        end else m_cen++;
      end else begin
        m_rtc++;
        if (m_rtc == RTCD) begin
          m_rtc = 0;
          m_st = m_st | 4;
        end
      end
    end
  endtask : pulse

  // Skips two periods so a new divider setting is in force, then times one
  task automatic measure(input int idx, output int hi, output int lo);
    int n;
    hi = 0;
    lo = 0;
    n = 0;
    repeat (2) begin
      while (obs[idx] !== 1'b0 && n < 4000) begin @(negedge clk); n++; end
      while (obs[idx] !== 1'b1 && n < 4000) begin @(negedge clk); n++; end
    end
    while (obs[idx] === 1'b1 && n < 4000) begin @(negedge clk); n++; hi++; end
    while (obs[idx] === 1'b0 && n < 4000) begin @(negedge clk); n++; lo++; end
  endtask : measure

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin : watchdog
    #400000;
    check(1'b0, 1'b1);
    wrap_up();
  end

  initial begin : main
    int hi, lo, d, dv;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check(fast_st, 1'b1);
    rd(REG_INFO, 1);
    rd(REG_CTRL, 0);
    rd(REG_FAST_TC, FAST_TC_RST);
    rd(REG_CEN_TC, CEN_TC_RST);
    rd(REG_BUS_DIV, DIV_RST);
    chk_ev();
    wr(8'h30, -1);
    rd(8'h30, 0);
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      wr(RA[i], d);
      rd(RA[i], d & RM[i]);
      wr(RA[i], d & 3);
    end
    $display("test registers finished");
    wr(REG_FAST_TC, 3);
    wr(REG_CEN_TC, 65535);
    wr(REG_MASK, 7);
    pulse(SRC_WATCH_XTAL, RTCD - 1);
    chk_ev();
    pulse(SRC_WATCH_XTAL, 1);
    chk_ev();
    wr(REG_STATUS, 4);
    chk_ev();
    $display("test seconds tick finished");
    wr(REG_CTRL, 8);
    pulse(SRC_LOW_SPEED, 3);
    chk_ev();
    pulse(SRC_LOW_SPEED, 1);
    chk_ev();
    rd(REG_COUNT, (m_cen << 16) | m_fast);
    wr(REG_STATUS, 1);
    wr(REG_CTRL, 0);
    pulse(SRC_LOW_SPEED, 4);
    chk_ev();
    rd(REG_COUNT, (m_cen << 16) | m_fast);
    wr(REG_CTRL, 32);
    rd(REG_COUNT, m_fast);
    wr(REG_CEN_TC, 1);
    wr(REG_CTRL, 16);
    pulse(SRC_LOW_SPEED, 1);
    chk_ev();
    pulse(SRC_LOW_SPEED, 1);
    chk_ev();
    $display("test interval counters finished");
    src_on <= 7'h08;
    measure(11, hi, lo);
    check(hi, 8);
    check(lo, 16);
    for (int s = 0; s < N_SRC; s++) begin
      wr(REG_CTRL, s);
      src_on <= 7'h01 << s;
      measure(8, hi, lo);
      check(hi, 4);
      check(lo, 4);
    end
    wr(REG_CTRL, 7);
    // Select lands at the completing edge; one more edge flushes the old level
    @(posedge clk);
    hi = 0;
    repeat (40) begin
      @(negedge clk);
      hi += (mclk !== 1'b0);
    end
    check(hi, 0);
    $display("test source select finished");
    wr(REG_CTRL, 0);
    src_on <= 7'h01;
    d = $unsigned($random(seed)) % 4;
    dv = $unsigned($random(seed)) % 2;
    wr(REG_BUS_DIV, d);
    wr(REG_CPU_DIV, dv);
    measure(9, hi, lo);
    check(hi, (d + 1) * 8);
    check(lo, (d + 1) * 8);
    measure(10, hi, lo);
    check(hi, (dv + 1) * (d + 1) * 16);
    check(lo, (dv + 1) * (d + 1) * 16);
    wr(REG_DCLK_SRC, 0);
    wr({DCLK_PAGE, 3'h0, 2'b00}, 1);
    measure(0, hi, lo);
    check(hi, 16);
    check(lo, 16);
    wr(REG_DCLK_SRC, 255);
    fab_on <= 8'hff;
    for (int i = 0; i < N_DCLK; i++) begin
      d = $unsigned($random(seed)) % 4;
      wr({DCLK_PAGE, 3'(i), 2'b00}, d);
      measure(i, hi, lo);
      check(hi, (d + 1) * 8);
      check(lo, (d + 1) * 8);
    end
    $display("test dividers finished");
    // Second reset with the startup option cleared
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check(fast_st, 1'b0);
    rd(REG_INFO, 0);
    rd(REG_BUS_DIV, DIV_RST);
    rd(REG_FAST_TC, FAST_TC_RST);
    $display("test second reset finished");
    wrap_up();
  end

endmodule : ctt_clock_tree_test

// File: ctt_pkg.sv
// Constants, register map and types of the clock tree and interval timers
package ctt_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int N_SRC   = 7;
  localparam int N_DCLK  = 8;
  localparam int N_IN    = N_SRC + N_DCLK;
  localparam int AW      = 8;
  localparam int DW      = 32;
  localparam int DIV_W   = 16;
  localparam int FAST_W  = 5;
  localparam int CEN_W   = 16;
  localparam int RTC_W   = 16;
  localparam int N_EV    = 3;

  // Source indices into the clock source vector
  localparam int SRC_MAIN_OSC   = 0;
  localparam int SRC_FAST_XTAL  = 1;
  localparam int SRC_WATCH_XTAL = 2;
  localparam int SRC_LOW_SPEED  = 3;
  localparam int SRC_PLL        = 4;
  localparam int SRC_FABRIC     = 5;
  localparam int SRC_AUX        = 6;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [AW-1:0] REG_CTRL     = 8'h00;
  localparam logic [AW-1:0] REG_BUS_DIV  = 8'h04;
  localparam logic [AW-1:0] REG_CPU_DIV  = 8'h08;
  localparam logic [AW-1:0] REG_FAST_TC  = 8'h0c;
  localparam logic [AW-1:0] REG_CEN_TC   = 8'h10;
  localparam logic [AW-1:0] REG_STATUS   = 8'h14;
  localparam logic [AW-1:0] REG_MASK     = 8'h18;
  localparam logic [AW-1:0] REG_COUNT    = 8'h1c;
  localparam logic [AW-1:0] REG_DCLK_SRC = 8'h20;
  localparam logic [AW-1:0] REG_INFO     = 8'h24;
  // Digital divider settings at 0x40 + 4*i
  localparam logic [2:0]    DCLK_PAGE    = 3'h2;
  localparam int            ADR_PG_MSB   = 7;
  localparam int            ADR_PG_LSB   = 5;
  localparam int            ADR_IX_MSB   = 4;
  localparam int            ADR_IX_LSB   = 2;

  // ----------------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------------
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_SEL_MSB = 2;
  localparam int CTRL_FAST_EN = 3;
  localparam int CTRL_WAKE_EN = 4;
  localparam int CTRL_CEN_RST = 5;
  localparam int EV_FAST      = 0;
  localparam int EV_CEN       = 1;
  localparam int EV_RTC       = 2;
  localparam int CNT_CEN_LSB  = 16;
  localparam int INFO_FAST_ST = 0;

  // Reset values and fixed counts
  localparam logic [DIV_W-1:0]  DIV_RST     = 16'h0000;
  localparam logic [FAST_W-1:0] FAST_TC_RST = 5'h1f;
  localparam logic [CEN_W-1:0]  CEN_TC_RST  = 16'hffff;
  localparam logic [2:0]        SEL_RST     = 3'h0;
  localparam logic [1:0]        THIRD_LAST  = 2'h2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic          read;
    logic          write;
    logic [AW-1:0] address;
    logic [DW-1:0] writedata;
  } ctt_avm_req_t;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] act;
    logic             out;
  } ctt_div_t;

  typedef struct packed {
    logic [2:0] master_sel;
    logic       fast_int_en;
    logic       wake_en;
  } ctt_ctrl_t;

  typedef struct packed {
    logic [N_IN-1:0]                s1;
    logic [N_IN-1:0]                s2;
    logic [N_IN-1:0]                s3;
    logic [N_IN-1:0]                lvl;
    logic                           ack;
    logic [DW-1:0]                  rdata;
    ctt_ctrl_t                      ctrl;
    ctt_div_t                       bus;
    ctt_div_t                       cpu;
    ctt_div_t [N_DCLK-1:0]          dclk;
    logic [DIV_W-1:0]               bus_div;
    logic [DIV_W-1:0]               cpu_div;
    logic [N_DCLK-1:0][DIV_W-1:0]   dclk_div;
    logic [N_DCLK-1:0]              dsrc;
    logic [FAST_W-1:0]              fast_tc;
    logic [FAST_W-1:0]              fast_cnt;
    logic [CEN_W-1:0]               cen_tc;
    logic [CEN_W-1:0]               cen_cnt;
    logic [1:0]                     third_cnt;
    logic [RTC_W-1:0]               rtc_cnt;
    logic [N_EV-1:0]                status;
    logic [N_EV-1:0]                mask;
    logic                           irq;
    logic                           wake;
    logic                           mclk;
    logic                           third;
    logic                           strap_done;
    logic                           fast_start;
  } ctt_state_t;

  // One source tick of a 50% divider; new setting loads at period end
  function automatic ctt_div_t ctt_div_step(ctt_div_t d, logic tick,
                                            logic [DIV_W-1:0] div);
    ctt_div_t n;
    n = d;
    if (tick) begin
      if (d.cnt == d.act) begin
        n.cnt = '0;
        n.out = ~d.out;
        if (d.out) begin
          n.act = div;
        end
      end else begin
        n.cnt = d.cnt + 16'h0001;
      end
    end
    return n;
  endfunction : ctt_div_step

endpackage : ctt_pkg
